// ==== verilog/aesc_pkg.sv ====
// Package of offsets, field positions and types for the acquisition strobe control.
package aesc_pkg;

    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 8;
    localparam int ENTRY_W = 8;
    localparam int DEPTH   = 16;
    localparam int PTR_W   = $clog2(DEPTH);
    localparam int CNT_W   = PTR_W + 1;

    // Strobe locations; reads and writes at one offset have distinct effects.
    localparam logic [ADDR_W-1:0] OFS_ACQ_ABORT  = 5'h19;
    localparam logic [ADDR_W-1:0] OFS_CFG_STROBE = 5'h1b;
    localparam logic [ADDR_W-1:0] OFS_ACQ_CONV   = 5'h1d;
    // Plain registers.
    localparam logic [ADDR_W-1:0] OFS_CFG_DATA   = 5'h01;
    localparam logic [ADDR_W-1:0] OFS_CONTROL    = 5'h03;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 5'h05;

    // Control register fields.
    localparam int CTL_BP_SEL  = 0;
    localparam int CTL_EXT_DIS = 1;
    localparam logic [1:0] CTL_RESET = 2'h0;

    // Status register fields.
    localparam int STS_ACTIVE = 0;
    localparam int STS_DONE   = 1;
    localparam int STS_LOST   = 2;
    localparam int STS_SPILL  = 3;
    localparam int STS_EMPTY  = 4;

    // Synchroniser idle level of the active-low pins.
    localparam logic [2:0] PIN_IDLE = 3'h7;

    typedef struct packed {
        logic ext_acq_trigger_disable;
        logic backplane_trigger_select;
    } aesc_ctrl_t;

    typedef struct packed {
        logic acq_done_flag;
        logic sample_lost;
        logic fifo_spill;
    } aesc_flags_t;

endpackage

// ==== verilog/aesc_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module aesc_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_stage1 = i_async;
        next_sync   = stage1;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            stage1 <= next_stage1;
            o_sync <= next_sync;
        end
    end

endmodule // aesc_sync

// ==== verilog/aesc_control.sv ====
// Analog-input event strobe decoder with channel configuration memory.
//
// Overview of operation
// - Strobe read 1B erases memory, rewinds write.
// - Wiped entries are lost for good.
// - Strobe write 1B applies entry, advances read.
// - After loading, advances apply entries in order.
// - Abort rewinds read position, no apply, keeps.
// - Strobe read 19 cancels acquisition, flushes FIFO.
// - Abort clears lost, spill, done; drops interrupt.
// - Strobe read 1D starts scanned acquisition.
// - Low external or backplane trigger starts acquisition.
// - Start strobe gated by select and disable bits.
// - Strobe write 1D fires exactly one conversion.
// - Low external convert fires one conversion.
`timescale 1ns/1ps
module aesc_control #(
    parameter int DEPTH   = aesc_pkg::DEPTH,
    parameter int ENTRY_W = aesc_pkg::ENTRY_W
) (
    // Clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rst_n,
    // Register port
    input  wire logic [aesc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [aesc_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [aesc_pkg::DATA_W-1:0] o_rdata,
    // Active-low pins
    input  wire logic                        i_ext_acq_trigger_n,
    input  wire logic                        i_backplane_acq_trigger_n,
    input  wire logic                        i_ext_convert_n,
    // Events from the acquisition datapath
    input  wire aesc_pkg::aesc_flags_t       i_flag_set,
    // Controls to the acquisition datapath
    output logic      [ENTRY_W-1:0]          o_cfg_entry,
    output logic                             o_cfg_apply,
    output logic                             o_acq_start,
    output logic                             o_acq_cancel,
    output logic                             o_fifo_flush,
    output logic                             o_irq_drop,
    output logic                             o_convert,
    output aesc_pkg::aesc_flags_t            o_flags
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and falling-edge detection

    logic [2:0] pins_sync;
    logic [2:0] pins_prev;
    logic [2:0] next_pins_prev;
    logic       ext_trig_fall;
    logic       bp_trig_fall;
    logic       conv_fall;

    // Pins are asynchronous; only the second stage of the synchroniser is read.
    aesc_sync #(
        .WIDTH     (3),
        .RESET_VAL (aesc_pkg::PIN_IDLE)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async ({i_ext_convert_n, i_backplane_acq_trigger_n, i_ext_acq_trigger_n}),
        .o_sync  (pins_sync)
    );

    always_comb begin
        next_pins_prev = pins_sync;
        ext_trig_fall  = pins_prev[0] & ~pins_sync[0];
        bp_trig_fall   = pins_prev[1] & ~pins_sync[1];
        conv_fall      = pins_prev[2] & ~pins_sync[2];
    end

    // The detectors reset to the idle high level, so a pin held low at release gives one edge once it is synchronised.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_prev <= aesc_pkg::PIN_IDLE;
        end else begin
            pins_prev <= next_pins_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access decode

    // Each strobe is one bus cycle wide, so each decode fires once per access.
    logic wipe_hit;
    logic advance_hit;
    logic abort_hit;
    logic begin_hit;
    logic shot_hit;
    logic entry_hit;
    logic ctrl_hit;

    always_comb begin
        wipe_hit    = i_rd & (i_addr == aesc_pkg::OFS_CFG_STROBE);
        advance_hit = i_wr & (i_addr == aesc_pkg::OFS_CFG_STROBE);
        abort_hit   = i_rd & (i_addr == aesc_pkg::OFS_ACQ_ABORT);
        begin_hit   = i_rd & (i_addr == aesc_pkg::OFS_ACQ_CONV);
        shot_hit    = i_wr & (i_addr == aesc_pkg::OFS_ACQ_CONV);
        entry_hit   = i_wr & (i_addr == aesc_pkg::OFS_CFG_DATA);
        ctrl_hit    = i_wr & (i_addr == aesc_pkg::OFS_CONTROL);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    // Both bits reset clear, so the start strobe and the external pin are live after reset.
    aesc_pkg::aesc_ctrl_t ctrl;
    aesc_pkg::aesc_ctrl_t next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_hit) begin
            next_ctrl.backplane_trigger_select = i_wdata[aesc_pkg::CTL_BP_SEL];
            next_ctrl.ext_acq_trigger_disable  = i_wdata[aesc_pkg::CTL_EXT_DIS];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= aesc_pkg::CTL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel configuration memory

    logic [ENTRY_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0]   wr_ptr;
    logic [PTR_W-1:0]   rd_ptr;
    logic [CNT_W-1:0]   count;
    logic [PTR_W-1:0]   next_wr_ptr;
    logic [PTR_W-1:0]   next_rd_ptr;
    logic [CNT_W-1:0]   next_count;
    logic               entry_store;

    // A full memory drops further entry writes; a scan then covers DEPTH entries only.
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        entry_store = entry_hit & (count != CNT_FULL);
        if (wipe_hit) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count  = '0;
        end else if (entry_store) begin
            next_wr_ptr = wr_ptr + 1'b1;
            next_count  = count + 1'b1;
            next_rd_ptr = '0;
        end else if (abort_hit) begin
            next_rd_ptr = '0;
        end else if (advance_hit) begin
            if ({1'b0, rd_ptr} + 1'b1 >= count) begin
                next_rd_ptr = '0;
            end else begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Erasing writes zero into every entry; there is no shadow copy to restore from.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (wipe_hit) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (entry_store) begin
            mem[wr_ptr] <= i_wdata[ENTRY_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Acquisition control, flags and output strobes

    aesc_pkg::aesc_flags_t next_flags;
    logic                  acq_active;
    logic                  next_acq_active;
    logic                  start_ok;
    logic                  start_any;
    logic [ENTRY_W-1:0]    next_cfg_entry;
    logic                  next_cfg_apply;
    logic                  next_acq_start;
    logic                  next_abort_pulse;
    logic                  next_convert;

    always_comb begin
        // A strobe start is refused while a pin trigger owns the start path.
        start_ok  = begin_hit & ~ctrl.backplane_trigger_select
                    & (pins_sync[0] | ctrl.ext_acq_trigger_disable);
        start_any = start_ok
                    | (ext_trig_fall & ~ctrl.ext_acq_trigger_disable)
                    | (bp_trig_fall & ctrl.backplane_trigger_select);
        next_acq_active = acq_active;
        if (abort_hit) begin
            next_acq_active = 1'b0;
        end else if (start_any) begin
            next_acq_active = 1'b1;
        end else if (i_flag_set.acq_done_flag) begin
            next_acq_active = 1'b0;
        end
        // A flag event in the abort cycle survives the clear.
        next_flags = abort_hit ? '0 : o_flags;
        next_flags = next_flags | i_flag_set;
        next_cfg_entry = advance_hit ? mem[rd_ptr] : o_cfg_entry;
        // Abort outranks a start in the same cycle, so a cancelled run never begins.
        next_cfg_apply   = advance_hit;
        next_acq_start   = start_any & ~abort_hit;
        next_abort_pulse = abort_hit;
        next_convert     = shot_hit | conv_fall;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acq_active   <= 1'b0;
            o_flags      <= '0;
            o_cfg_entry  <= '0;
            o_cfg_apply  <= 1'b0;
            o_acq_start  <= 1'b0;
            o_acq_cancel <= 1'b0;
            o_fifo_flush <= 1'b0;
            o_irq_drop   <= 1'b0;
            o_convert    <= 1'b0;
        end else begin
            acq_active   <= next_acq_active;
            o_flags      <= next_flags;
            o_cfg_entry  <= next_cfg_entry;
            o_cfg_apply  <= next_cfg_apply;
            o_acq_start  <= next_acq_start;
            o_acq_cancel <= next_abort_pulse;
            o_fifo_flush <= next_abort_pulse;
            o_irq_drop   <= next_abort_pulse;
            o_convert    <= next_convert;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [aesc_pkg::DATA_W-1:0] next_rdata;

    always_comb begin
        // Strobe reads and unmapped reads return zero; write data of strobes is unused.
        next_rdata = '0;
        if (i_rd) begin
            case (i_addr)
                aesc_pkg::OFS_CONTROL: begin
                    next_rdata[aesc_pkg::CTL_BP_SEL]  = ctrl.backplane_trigger_select;
                    next_rdata[aesc_pkg::CTL_EXT_DIS] = ctrl.ext_acq_trigger_disable;
                end
                aesc_pkg::OFS_STATUS: begin
                    next_rdata[aesc_pkg::STS_ACTIVE] = acq_active;
                    next_rdata[aesc_pkg::STS_DONE]   = o_flags.acq_done_flag;
                    next_rdata[aesc_pkg::STS_LOST]   = o_flags.sample_lost;
                    next_rdata[aesc_pkg::STS_SPILL]  = o_flags.fifo_spill;
                    next_rdata[aesc_pkg::STS_EMPTY]  = (count == '0);
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= next_rdata;
        end
    end

endmodule // aesc_control

// ==== verification/aesc_control_props.sv ====
// Port-level checks for the acquisition strobe control.
`timescale 1ns/1ps
module aesc_control_props (
    // Clock and reset
    input wire logic                        i_clock,
    input wire logic                        i_rst_n,
    // Register port
    input wire logic [aesc_pkg::ADDR_W-1:0] i_addr,
    input wire logic                        i_wr,
    input wire logic                        i_rd,
    input wire logic [aesc_pkg::DATA_W-1:0] o_rdata,
    // Pins and datapath
    input wire logic                        i_ext_convert_n,
    input wire aesc_pkg::aesc_flags_t       i_flag_set,
    input wire logic                        o_cfg_apply,
    input wire logic                        o_acq_start,
    input wire logic                        o_acq_cancel,
    input wire logic                        o_fifo_flush,
    input wire logic                        o_irq_drop,
    input wire logic                        o_convert,
    input wire aesc_pkg::aesc_flags_t       o_flags
);
    logic abort_rd;
    logic wipe_rd;
    logic start_rd;
    logic adv_wr;
    logic conv_wr;
    assign abort_rd = i_rd && i_addr == aesc_pkg::OFS_ACQ_ABORT;
    assign wipe_rd  = i_rd && i_addr == aesc_pkg::OFS_CFG_STROBE;
    assign start_rd = i_rd && i_addr == aesc_pkg::OFS_ACQ_CONV;
    assign adv_wr   = i_wr && i_addr == aesc_pkg::OFS_CFG_STROBE;
    assign conv_wr  = i_wr && i_addr == aesc_pkg::OFS_ACQ_CONV;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    a_abort_pulses: assert property (
        abort_rd |=> o_acq_cancel && o_fifo_flush && o_irq_drop)
        else $error("abort gave no cancel pulses");
    a_abort_flags: assert property (
        abort_rd && i_flag_set == 3'h0 |=> o_flags == 3'h0)
        else $error("abort left flags set");
    a_abort_keep: assert property (abort_rd |=> !o_cfg_apply)
        else $error("abort applied an entry");
    a_advance_apply: assert property (adv_wr |=> o_cfg_apply)
        else $error("advance gave no apply");
    a_apply_cause: assert property (o_cfg_apply |-> $past(adv_wr))
        else $error("apply without advance");
    a_convert_once: assert property (conv_wr |=> o_convert ##1 !o_convert)
        else $error("convert strobe not one pulse");
    a_pin_convert: assert property ($fell(i_ext_convert_n) |-> ##[1:6] o_convert)
        else $error("convert pin gave no pulse");
    a_wipe_quiet: assert property (
        wipe_rd |=> !o_cfg_apply && !o_convert && !o_acq_start)
        else $error("wipe caused a side pulse");
    a_strobe_rdata: assert property (
        abort_rd || wipe_rd || start_rd |=> o_rdata == 8'h00)
        else $error("strobe read data not zero");
    c_start: cover property (o_acq_start);
    c_pin_conv: cover property ($fell(i_ext_convert_n));
    c_abort: cover property (abort_rd ##1 o_acq_cancel);
endmodule // aesc_control_props

bind aesc_control aesc_control_props u_props (
    .i_clock, .i_rst_n, .i_addr, .i_wr, .i_rd, .o_rdata, .i_ext_convert_n, .i_flag_set,
    .o_cfg_apply, .o_acq_start, .o_acq_cancel, .o_fifo_flush, .o_irq_drop, .o_convert, .o_flags
);

// ==== verification/aesc_host.sv ====
// Host model issuing strobe and register accesses on the plain port.
`timescale 1ns/1ps
module aesc_host (
    // Clock
    input  wire logic                        i_clock,
    // Register port
    output logic      [aesc_pkg::ADDR_W-1:0] o_addr,
    output logic      [aesc_pkg::DATA_W-1:0] o_wdata,
    output logic                             o_wr,
    output logic                             o_rd,
    input  wire logic [aesc_pkg::DATA_W-1:0] i_rdata
);
    initial begin
        o_addr  = 5'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // Released data is inverted so a stale bus value never looks valid.
    task automatic put(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        #1;
    endtask
    task automatic get(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule // aesc_host

// ==== verification/adc_event_strobe_control_tb_top.sv ====
// Self-checking bench for the acquisition strobe control.
`timescale 1ns/1ps
module adc_event_strobe_control_tb_top;
    logic                  i_clock = 1'b0;
    logic                  i_rst_n = 1'b0;
    logic [4:0]            addr;
    logic [7:0]            wdata, rdata, entry, d, s;
    logic                  wr, rd, apply, start, cancel, flush, drop, conv;
    logic                  ext_trg_n = 1'b1, bp_trg_n = 1'b1, conv_n = 1'b1;
    aesc_pkg::aesc_flags_t flag_set = 3'h0;
    aesc_pkg::aesc_flags_t flags;
    logic [7:0]            n_apply = 8'h00, n_start = 8'h00, n_abort = 8'h00, n_conv = 8'h00;
    int                    err_count = 0;
    int                    n_compared = 0;
    aesc_host host (.i_clock, .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .i_rdata(rdata));
    aesc_control dut (.i_clock, .i_rst_n, .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_ext_acq_trigger_n(ext_trg_n),
        .i_backplane_acq_trigger_n(bp_trg_n), .i_ext_convert_n(conv_n),
        .i_flag_set(flag_set), .o_cfg_entry(entry), .o_cfg_apply(apply),
        .o_acq_start(start), .o_acq_cancel(cancel), .o_fifo_flush(flush),
        .o_irq_drop(drop), .o_convert(conv), .o_flags(flags));
    always #2 i_clock = ~i_clock;
    // Pulse counters let each scenario judge exactly how many effects one access had.
    always @(posedge i_clock) begin
        n_apply <= n_apply + 8'(apply);
        n_start <= n_start + 8'(start);
        n_conv  <= n_conv + 8'(conv);
        n_abort <= n_abort + 8'(cancel && flush && drop);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic complete_run();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_load();
        host.get(aesc_pkg::OFS_CFG_STROBE, d);
        chk(d, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host.put(aesc_pkg::OFS_CFG_DATA, 8'ha0 + 8'(i));
        end
        s = n_apply;
        for (int i = 0; i < 4; i++) begin
            host.put(aesc_pkg::OFS_CFG_STROBE, 8'hff);
            chk(entry, 8'ha0 + 8'(i % 3));
        end
        host.get(aesc_pkg::OFS_CFG_STROBE, d);
        host.put(aesc_pkg::OFS_CFG_STROBE, 8'h00);
        chk(entry, 8'h00);
        tick(1);
        chk(n_apply - s, 8'h05);
    endtask
    task automatic t_abort();
        host.put(aesc_pkg::OFS_CFG_DATA, 8'h11);
        host.put(aesc_pkg::OFS_CFG_DATA, 8'h22);
        host.put(aesc_pkg::OFS_CFG_DATA, 8'h33);
        host.put(aesc_pkg::OFS_CFG_STROBE, 8'h00);
        chk(entry, 8'h11);
        host.put(aesc_pkg::OFS_CFG_STROBE, 8'h00);
        @(posedge i_clock);
        flag_set <= 3'h7;
        @(posedge i_clock);
        flag_set <= 3'h0;
        tick(1);
        chk(8'(flags), 8'h07);
        host.get(aesc_pkg::OFS_STATUS, d);
        chk(d, 8'h0e);
        s = n_abort;
        host.get(aesc_pkg::OFS_ACQ_ABORT, d);
        chk(entry, 8'h22);
        tick(1);
        chk(n_abort - s, 8'h01);
        chk(8'(flags), 8'h00);
        host.get(aesc_pkg::OFS_STATUS, d);
        chk(d, 8'h00);
        host.put(aesc_pkg::OFS_CFG_STROBE, 8'h00);
        chk(entry, 8'h11);
    endtask
    task automatic t_start();
        host.put(aesc_pkg::OFS_CONTROL, 8'h01);
        host.get(aesc_pkg::OFS_CONTROL, d);
        chk(d, 8'h01);
        s = n_start;
        host.get(aesc_pkg::OFS_ACQ_CONV, d);
        tick(1);
        chk(n_start - s, 8'h00);
        @(posedge i_clock);
        bp_trg_n <= 1'b0;
        tick(6);
        chk(n_start - s, 8'h01);
        @(posedge i_clock);
        bp_trg_n <= 1'b1;
        host.put(aesc_pkg::OFS_CONTROL, 8'h00);
        host.get(aesc_pkg::OFS_ACQ_CONV, d);
        tick(1);
        chk(n_start - s, 8'h02);
        @(posedge i_clock);
        ext_trg_n <= 1'b0;
        tick(6);
        chk(n_start - s, 8'h03);
        host.get(aesc_pkg::OFS_ACQ_CONV, d);
        host.put(aesc_pkg::OFS_CONTROL, 8'h02);
        host.get(aesc_pkg::OFS_ACQ_CONV, d);
        tick(1);
        chk(n_start - s, 8'h04);
        host.get(aesc_pkg::OFS_STATUS, d);
        chk(d, 8'h01);
        host.get(5'h0a, d);
        chk(d, 8'h00);
        @(posedge i_clock);
        ext_trg_n <= 1'b1;
    endtask
    task automatic t_conv();
        s = n_conv;
        host.put(aesc_pkg::OFS_ACQ_CONV, 8'h5a);
        tick(1);
        chk(n_conv - s, 8'h01);
        @(posedge i_clock);
        conv_n <= 1'b0;
        tick(6);
        @(posedge i_clock);
        conv_n <= 1'b1;
        tick(4);
        chk(n_conv - s, 8'h02);
    endtask
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        tick(2);
        t_load();
        t_abort();
        t_start();
        t_conv();
        complete_run();
    end
    initial begin
        #50000;
        err_count++;
        complete_run();
    end
endmodule // adc_event_strobe_control_tb_top
